// ---- rtl/tad_pkg.sv ----
package tad_pkg;

    // ------------------------------------------------------------
    // decoded operation classes
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        OP_OTHER        = 6'b000000, OP_MOV_RM      = 6'b000001,
        OP_MOV_IMM_RM   = 6'b000010, OP_MOV_IMM_REG = 6'b000011,
        OP_MOV_MEM_ACC  = 6'b000100, OP_MOV_ACC_MEM = 6'b000101,
        OP_MOV_TO_SEG   = 6'b000110, OP_MOV_FROM_SEG = 6'b000111,
        OP_PUSH_RM      = 6'b001000, OP_PUSH_REG    = 6'b001001,
        OP_PUSH_SEG     = 6'b001010, OP_POP_RM      = 6'b001011,
        OP_POP_REG      = 6'b001100, OP_POP_SEG     = 6'b001101,
        OP_EXCHANGE_RM  = 6'b001110, OP_EXCHANGE_ACC = 6'b001111,
        OP_IN_FIXED     = 6'b010000, OP_IN_VAR      = 6'b010001,
        OP_OUT_FIXED    = 6'b010010, OP_OUT_VAR     = 6'b010011,
        table_translate_op        = 6'b010100,
        load_effective_offset_op  = 6'b010101,
        load_pointer_data_seg_op  = 6'b010110,
        load_pointer_extra_seg_op = 6'b010111,
        flags_to_high_acc_op      = 6'b011000,
        high_acc_to_flags_op      = 6'b011001,
        OP_PUSH_FLAGS   = 6'b011010, OP_POP_FLAGS   = 6'b011011,
        OP_ADD_RM       = 6'b011100, OP_ADD_IMM_RM  = 6'b011101,
        OP_ADD_ACC      = 6'b011110, OP_ADC_RM      = 6'b011111,
        OP_ADC_IMM_RM   = 6'b100000, OP_ADC_ACC     = 6'b100001,
        OP_INC_RM       = 6'b100010, OP_INC_REG     = 6'b100011,
        unpacked_add_adjust_op    = 6'b100100,
        packed_add_adjust_op      = 6'b100101,
        OP_SUB_RM       = 6'b100110, OP_SUB_IMM_RM  = 6'b100111,
        OP_SUB_ACC      = 6'b101000,
        subtract_with_borrow_op   = 6'b101001,
        OP_BORROW_IMM_RM = 6'b101010, OP_BORROW_ACC = 6'b101011,
        OP_DEC_RM       = 6'b101100, OP_DEC_REG     = 6'b101101,
        OP_NEG          = 6'b101110, OP_CMP_RM      = 6'b101111,
        OP_CMP_IMM_RM   = 6'b110000, OP_CMP_ACC     = 6'b110001
    } tad_op_e;

    typedef enum logic [2:0] {
        ST_FIRST = 3'b000, ST_MODRM = 3'b001, ST_DISP_LO = 3'b010,
        ST_DISP_HI = 3'b011, ST_IMM_LO = 3'b100, ST_IMM_HI = 3'b101
    } tad_state_e;

    typedef enum logic [1:0] {
        GRP_NONE = 2'b00, GRP_IMM = 2'b01, GRP_INCDEC = 2'b10,
        GRP_UNARY = 2'b11
    } tad_grp_e;

    // ------------------------------------------------------------
    // first-byte patterns
    // ------------------------------------------------------------
    localparam logic [7:0] P_MOV_RM      = 8'b100010??;
    localparam logic [7:0] P_MOV_IMM_RM  = 8'b1100011?;
    localparam logic [7:0] P_MOV_IMM_REG = 8'b1011????;
    localparam logic [7:0] P_MOV_MEM_ACC = 8'b1010000?;
    localparam logic [7:0] P_MOV_ACC_MEM = 8'b1010001?;
    localparam logic [7:0] P_MOV_TO_SEG  = 8'h8e;
    localparam logic [7:0] P_MOV_FROM_SEG = 8'h8c;
    localparam logic [7:0] P_GRP_INCDEC  = 8'b1111111?;
    localparam logic [7:0] P_PUSH_REG    = 8'b01010???;
    localparam logic [7:0] P_PUSH_SEG    = 8'b000??110;
    localparam logic [7:0] P_POP_RM      = 8'h8f;
    localparam logic [7:0] P_POP_REG     = 8'b01011???;
    localparam logic [7:0] P_POP_SEG     = 8'b000??111;
    localparam logic [7:0] P_EXCH_RM     = 8'b1000011?;
    localparam logic [7:0] P_EXCH_ACC    = 8'b10010???;
    localparam logic [7:0] P_IN_FIXED    = 8'b1110010?;
    localparam logic [7:0] P_IN_VAR      = 8'b1110110?;
    localparam logic [7:0] P_OUT_FIXED   = 8'b1110011?;
    localparam logic [7:0] P_OUT_VAR     = 8'b1110111?;
    localparam logic [7:0] P_TRANSLATE   = 8'hd7;
    localparam logic [7:0] P_LOAD_EFF    = 8'h8d;
    localparam logic [7:0] P_PTR_DATA    = 8'hc5;
    localparam logic [7:0] P_PTR_EXTRA   = 8'hc4;
    localparam logic [7:0] P_FLAGS_TO_AH = 8'h9f;
    localparam logic [7:0] P_AH_TO_FLAGS = 8'h9e;
    localparam logic [7:0] P_PUSH_FLAGS  = 8'h9c;
    localparam logic [7:0] P_POP_FLAGS   = 8'h9d;
    localparam logic [7:0] P_ADD_RM      = 8'b000000??;
    localparam logic [7:0] P_ADD_ACC     = 8'b0000010?;
    localparam logic [7:0] P_ADC_RM      = 8'b000100??;
    localparam logic [7:0] P_ADC_ACC     = 8'b0001010?;
    localparam logic [7:0] P_GRP_IMM     = 8'b100000??;
    localparam logic [7:0] P_INC_REG     = 8'b01000???;
    localparam logic [7:0] P_DEC_REG     = 8'b01001???;
    localparam logic [7:0] P_UNPK_ADJ    = 8'h37;
    localparam logic [7:0] P_PACK_ADJ    = 8'h27;
    localparam logic [7:0] P_SUB_RM      = 8'b001010??;
    localparam logic [7:0] P_SUB_ACC     = 8'b0010110?;
    localparam logic [7:0] P_BORROW_RM   = 8'b000110??;
    localparam logic [7:0] P_BORROW_ACC  = 8'b0001110?;
    localparam logic [7:0] P_GRP_UNARY   = 8'b1111011?;
    localparam logic [7:0] P_CMP_RM      = 8'b001110??;
    localparam logic [7:0] P_CMP_ACC     = 8'b0011110?;

    // ------------------------------------------------------------
    // extension codes, field positions, reset values
    // ------------------------------------------------------------
    localparam logic [2:0] EXT_ADD = 3'h0;
    localparam logic [2:0] EXT_ADC = 3'h2;
    localparam logic [2:0] EXT_BORROW = 3'h3;
    localparam logic [2:0] EXT_SUB = 3'h5;
    localparam logic [2:0] EXT_CMP = 3'h7;
    localparam logic [2:0] EXT_INC = 3'h0;
    localparam logic [2:0] EXT_DEC = 3'h1;
    localparam logic [2:0] EXT_PUSH = 3'h6;
    localparam logic [2:0] EXT_TEST = 3'h0;
    localparam logic [2:0] EXT_NEG = 3'h3;
    localparam logic [1:0] MOD_NODISP = 2'h0;
    localparam logic [1:0] MOD_DISP8 = 2'h1;
    localparam logic [1:0] MOD_DISP16 = 2'h2;
    localparam logic [2:0] RM_DIRECT = 3'h6;
    localparam logic [1:0] SW_WORD_IMM = 2'h1;
    localparam int W_BIT = 0;
    localparam int D_BIT = 1;
    localparam int S_BIT = 1;
    localparam int REG8_W_BIT = 3;
    localparam logic [2:0] LEN_ONE = 3'h1;
    localparam logic [15:0] WORD_RST = 16'h0000;

endpackage

// ---- rtl/tad_decoder.sv ----
`timescale 1ns/1ps

// What this block does
// - 11010111 alone decodes as table translate
// - 10001101 plus addressing byte: load offset
// - 11000101/11000100 pointer loads, one addressing byte
// - 10011111 flags to AH, 10011110 back
// - 00110111 alone: unpacked add adjust
// - 00100111 alone: packed add adjust
// - 000000dw add with addressing byte
// - 001010dw subtract with addressing byte
// - add-carry register, group 010, accumulator forms
// - borrow-subtract register, group 011, accumulator forms
module tad_decoder (
    input  wire logic            ref_clk,
    input  wire logic            rst_b,
    input  wire logic            flush,
    input  wire logic            in_valid,
    input  wire logic [7:0]      in_byte,
    output tad_pkg::tad_op_e     insn_op,
    output logic                 insn_valid,
    output logic                 wide,
    output logic                 dir_to_reg,
    output logic                 sign_ext,
    output logic                 has_modrm,
    output logic [1:0]           mode_field,
    output logic [2:0]           reg_field,
    output logic [2:0]           rm_field,
    output logic [15:0]          disp_word,
    output logic [15:0]          imm_word,
    output logic [2:0]           insn_len
);

    // ------------------------------------------------------------
    // working state
    // ------------------------------------------------------------
    tad_pkg::tad_state_e state;
    tad_pkg::tad_state_e next_state;
    tad_pkg::tad_grp_e   grp;
    logic [1:0]          disp_n;
    logic [1:0]          imm_n;

    // ------------------------------------------------------------
    // first-byte classification
    // ------------------------------------------------------------
    tad_pkg::tad_op_e fb_op;
    tad_pkg::tad_grp_e fb_grp;
    logic             fb_modrm;
    logic             fb_dw;
    logic [1:0]       fb_imm;
    logic             fb_w;
    wire  logic [1:0] imm_by_w = in_byte[tad_pkg::W_BIT] ? 2'd2 : 2'd1;
    wire  logic       seg_form = (in_byte ==? tad_pkg::P_PUSH_SEG) ||
                                 (in_byte ==? tad_pkg::P_POP_SEG);
    wire  logic [2:0] fb_reg = seg_form ? {1'b0, in_byte[4:3]}
                                        : in_byte[2:0];

    always_comb begin
        fb_op = tad_pkg::OP_OTHER;
        fb_grp = tad_pkg::GRP_NONE;
        fb_modrm = 1'b0;
        fb_dw = 1'b0;
        fb_imm = 2'd0;
        fb_w = in_byte[tad_pkg::W_BIT];
        casez (in_byte)
            tad_pkg::P_MOV_RM: begin
                fb_op = tad_pkg::OP_MOV_RM;
                fb_modrm = 1'b1;
                fb_dw = 1'b1;
            end
            tad_pkg::P_MOV_IMM_RM: begin
                fb_op = tad_pkg::OP_MOV_IMM_RM;
                fb_modrm = 1'b1;
                fb_imm = imm_by_w;
            end
            tad_pkg::P_MOV_IMM_REG: begin
                fb_op = tad_pkg::OP_MOV_IMM_REG;
                fb_w = in_byte[tad_pkg::REG8_W_BIT];
                fb_imm = in_byte[tad_pkg::REG8_W_BIT] ? 2'd2 : 2'd1;
            end
            tad_pkg::P_MOV_MEM_ACC: begin
                fb_op = tad_pkg::OP_MOV_MEM_ACC;
                fb_imm = 2'd2;
            end
            tad_pkg::P_MOV_ACC_MEM: begin
                fb_op = tad_pkg::OP_MOV_ACC_MEM;
                fb_imm = 2'd2;
            end
            tad_pkg::P_MOV_TO_SEG: begin
                fb_op = tad_pkg::OP_MOV_TO_SEG;
                fb_modrm = 1'b1;
                fb_w = 1'b1;
            end
            tad_pkg::P_MOV_FROM_SEG: begin
                fb_op = tad_pkg::OP_MOV_FROM_SEG;
                fb_modrm = 1'b1;
                fb_w = 1'b1;
            end
            tad_pkg::P_GRP_INCDEC: begin
                fb_grp = tad_pkg::GRP_INCDEC;
                fb_modrm = 1'b1;
            end
            tad_pkg::P_PUSH_REG: begin
                fb_op = tad_pkg::OP_PUSH_REG;
                fb_w = 1'b1;
            end
            tad_pkg::P_PUSH_SEG: begin
                fb_op = tad_pkg::OP_PUSH_SEG;
                fb_w = 1'b1;
            end
            tad_pkg::P_POP_RM: begin
                fb_op = tad_pkg::OP_POP_RM;
                fb_modrm = 1'b1;
                fb_w = 1'b1;
            end
            tad_pkg::P_POP_REG: begin
                fb_op = tad_pkg::OP_POP_REG;
                fb_w = 1'b1;
            end
            tad_pkg::P_POP_SEG: begin
                fb_op = tad_pkg::OP_POP_SEG;
                fb_w = 1'b1;
            end
            tad_pkg::P_EXCH_RM: begin
                fb_op = tad_pkg::OP_EXCHANGE_RM;
                fb_modrm = 1'b1;
            end
            tad_pkg::P_EXCH_ACC: begin
                fb_op = tad_pkg::OP_EXCHANGE_ACC;
                fb_w = 1'b1;
            end
            tad_pkg::P_IN_FIXED: begin
                fb_op = tad_pkg::OP_IN_FIXED;
                fb_imm = 2'd1;
            end
            tad_pkg::P_IN_VAR: fb_op = tad_pkg::OP_IN_VAR;
            tad_pkg::P_OUT_FIXED: begin
                fb_op = tad_pkg::OP_OUT_FIXED;
                fb_imm = 2'd1;
            end
            tad_pkg::P_OUT_VAR: fb_op = tad_pkg::OP_OUT_VAR;
            tad_pkg::P_TRANSLATE: begin
                fb_op = tad_pkg::table_translate_op;
                fb_w = 1'b0;
            end
            tad_pkg::P_LOAD_EFF: begin
                fb_op = tad_pkg::load_effective_offset_op;
                fb_modrm = 1'b1;
            end
            tad_pkg::P_PTR_DATA: begin
                fb_op = tad_pkg::load_pointer_data_seg_op;
                fb_modrm = 1'b1;
                fb_w = 1'b1;
            end
            tad_pkg::P_PTR_EXTRA: begin
                fb_op = tad_pkg::load_pointer_extra_seg_op;
                fb_modrm = 1'b1;
                fb_w = 1'b1;
            end
            tad_pkg::P_FLAGS_TO_AH: fb_op = tad_pkg::flags_to_high_acc_op;
            tad_pkg::P_AH_TO_FLAGS: fb_op = tad_pkg::high_acc_to_flags_op;
            tad_pkg::P_PUSH_FLAGS: fb_op = tad_pkg::OP_PUSH_FLAGS;
            tad_pkg::P_POP_FLAGS: fb_op = tad_pkg::OP_POP_FLAGS;
            tad_pkg::P_ADD_RM: begin
                fb_op = tad_pkg::OP_ADD_RM;
                fb_modrm = 1'b1;
                fb_dw = 1'b1;
            end
            tad_pkg::P_ADD_ACC: begin
                fb_op = tad_pkg::OP_ADD_ACC;
                fb_imm = imm_by_w;
            end
            tad_pkg::P_ADC_RM: begin
                fb_op = tad_pkg::OP_ADC_RM;
                fb_modrm = 1'b1;
                fb_dw = 1'b1;
            end
            tad_pkg::P_ADC_ACC: begin
                fb_op = tad_pkg::OP_ADC_ACC;
                fb_imm = imm_by_w;
            end
            tad_pkg::P_GRP_IMM: begin
                fb_grp = tad_pkg::GRP_IMM;
                fb_modrm = 1'b1;
                fb_imm = (in_byte[1:0] == tad_pkg::SW_WORD_IMM) ? 2'd2
                                                                : 2'd1;
            end
            tad_pkg::P_INC_REG: begin
                fb_op = tad_pkg::OP_INC_REG;
                fb_w = 1'b1;
            end
            tad_pkg::P_DEC_REG: begin
                fb_op = tad_pkg::OP_DEC_REG;
                fb_w = 1'b1;
            end
            tad_pkg::P_UNPK_ADJ: fb_op = tad_pkg::unpacked_add_adjust_op;
            tad_pkg::P_PACK_ADJ: fb_op = tad_pkg::packed_add_adjust_op;
            tad_pkg::P_SUB_RM: begin
                fb_op = tad_pkg::OP_SUB_RM;
                fb_modrm = 1'b1;
                fb_dw = 1'b1;
            end
            tad_pkg::P_SUB_ACC: begin
                fb_op = tad_pkg::OP_SUB_ACC;
                fb_imm = imm_by_w;
            end
            tad_pkg::P_BORROW_RM: begin
                fb_op = tad_pkg::subtract_with_borrow_op;
                fb_modrm = 1'b1;
                fb_dw = 1'b1;
            end
            tad_pkg::P_BORROW_ACC: begin
                fb_op = tad_pkg::OP_BORROW_ACC;
                fb_imm = imm_by_w;
            end
            tad_pkg::P_GRP_UNARY: begin
                fb_grp = tad_pkg::GRP_UNARY;
                fb_modrm = 1'b1;
            end
            tad_pkg::P_CMP_RM: begin
                fb_op = tad_pkg::OP_CMP_RM;
                fb_modrm = 1'b1;
                fb_dw = 1'b1;
            end
            tad_pkg::P_CMP_ACC: begin
                fb_op = tad_pkg::OP_CMP_ACC;
                fb_imm = imm_by_w;
            end
            default: fb_op = tad_pkg::OP_OTHER;
        endcase
    end

    // ------------------------------------------------------------
    // addressing-byte resolution
    // ------------------------------------------------------------
    wire logic [1:0] mr_mod = in_byte[7:6];
    wire logic [2:0] mr_ext = in_byte[5:3];
    wire logic [1:0] mr_disp =
        (mr_mod == tad_pkg::MOD_DISP8) ? 2'd1 :
        (mr_mod == tad_pkg::MOD_DISP16) ? 2'd2 :
        (mr_mod == tad_pkg::MOD_NODISP &&
         in_byte[2:0] == tad_pkg::RM_DIRECT) ? 2'd2 : 2'd0;
    wire logic [1:0] mr_imm =
        (grp == tad_pkg::GRP_UNARY && mr_ext == tad_pkg::EXT_TEST)
            ? (wide ? 2'd2 : 2'd1) : imm_n;
    tad_pkg::tad_op_e mr_op;

    always_comb begin
        mr_op = insn_op;
        case (grp)
            tad_pkg::GRP_IMM: begin
                case (mr_ext)
                    tad_pkg::EXT_ADD: mr_op = tad_pkg::OP_ADD_IMM_RM;
                    tad_pkg::EXT_ADC: mr_op = tad_pkg::OP_ADC_IMM_RM;
                    tad_pkg::EXT_BORROW: mr_op = tad_pkg::OP_BORROW_IMM_RM;
                    tad_pkg::EXT_SUB: mr_op = tad_pkg::OP_SUB_IMM_RM;
                    tad_pkg::EXT_CMP: mr_op = tad_pkg::OP_CMP_IMM_RM;
                    default: mr_op = tad_pkg::OP_OTHER;
                endcase
            end
            tad_pkg::GRP_INCDEC: begin
                case (mr_ext)
                    tad_pkg::EXT_INC: mr_op = tad_pkg::OP_INC_RM;
                    tad_pkg::EXT_DEC: mr_op = tad_pkg::OP_DEC_RM;
                    tad_pkg::EXT_PUSH: mr_op = tad_pkg::OP_PUSH_RM;
                    default: mr_op = tad_pkg::OP_OTHER;
                endcase
            end
            tad_pkg::GRP_UNARY: begin
                mr_op = (mr_ext == tad_pkg::EXT_NEG) ? tad_pkg::OP_NEG
                                                     : tad_pkg::OP_OTHER;
            end
            default: mr_op = insn_op;
        endcase
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    wire logic [1:0] cur_disp = (state == tad_pkg::ST_MODRM) ? mr_disp
                                                           : disp_n;
    wire logic [1:0] cur_imm = (state == tad_pkg::ST_FIRST) ? fb_imm :
                               (state == tad_pkg::ST_MODRM) ? mr_imm : imm_n;
    wire logic       imm_next = (cur_imm != 2'd0);
    wire tad_pkg::tad_state_e after_disp =
        imm_next ? tad_pkg::ST_IMM_LO : tad_pkg::ST_FIRST;

    always_comb begin
        next_state = state;
        case (state)
            tad_pkg::ST_FIRST:
                next_state = fb_modrm ? tad_pkg::ST_MODRM : after_disp;
            tad_pkg::ST_MODRM:
                next_state = (cur_disp != 2'd0) ? tad_pkg::ST_DISP_LO
                                                : after_disp;
            tad_pkg::ST_DISP_LO:
                next_state = (disp_n == 2'd2) ? tad_pkg::ST_DISP_HI
                                              : after_disp;
            tad_pkg::ST_DISP_HI: next_state = after_disp;
            tad_pkg::ST_IMM_LO:
                next_state = (imm_n == 2'd2) ? tad_pkg::ST_IMM_HI
                                             : tad_pkg::ST_FIRST;
            tad_pkg::ST_IMM_HI: next_state = tad_pkg::ST_FIRST;
            default: next_state = tad_pkg::ST_FIRST;
        endcase
    end

    wire logic done = in_valid && next_state == tad_pkg::ST_FIRST;
    wire logic [7:0] ext_hi = (sign_ext && wide) ? {8{in_byte[7]}} : 8'h00;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= tad_pkg::ST_FIRST;
            grp <= tad_pkg::GRP_NONE;
            disp_n <= 2'd0;
            imm_n <= 2'd0;
            insn_op <= tad_pkg::OP_OTHER;
            insn_valid <= 1'b0;
            wide <= 1'b0;
            dir_to_reg <= 1'b0;
            sign_ext <= 1'b0;
            has_modrm <= 1'b0;
            mode_field <= 2'd0;
            reg_field <= 3'd0;
            rm_field <= 3'd0;
            disp_word <= tad_pkg::WORD_RST;
            imm_word <= tad_pkg::WORD_RST;
            insn_len <= 3'd0;
        end else if (flush) begin
            state <= tad_pkg::ST_FIRST;
            insn_valid <= 1'b0;
        end else begin
            insn_valid <= done;
            if (in_valid) begin
                state <= next_state;
                insn_len <= insn_len + 3'd1;
                case (state)
                    tad_pkg::ST_FIRST: begin
                        insn_len <= tad_pkg::LEN_ONE;
                        insn_op <= fb_op;
                        grp <= fb_grp;
                        imm_n <= fb_imm;
                        disp_n <= 2'd0;
                        has_modrm <= fb_modrm;
                        wide <= fb_w;
                        dir_to_reg <= fb_dw & in_byte[tad_pkg::D_BIT];
                        sign_ext <= (fb_grp == tad_pkg::GRP_IMM) &
                                    in_byte[tad_pkg::S_BIT];
                        mode_field <= 2'd0;
                        reg_field <= fb_reg;
                        rm_field <= 3'd0;
                        disp_word <= tad_pkg::WORD_RST;
                        imm_word <= tad_pkg::WORD_RST;
                    end
                    tad_pkg::ST_MODRM: begin
                        insn_op <= mr_op;
                        disp_n <= mr_disp;
                        imm_n <= mr_imm;
                        mode_field <= mr_mod;
                        reg_field <= mr_ext;
                        rm_field <= in_byte[2:0];
                    end
                    tad_pkg::ST_DISP_LO:
                        disp_word <= {{8{in_byte[7]}}, in_byte};
                    tad_pkg::ST_DISP_HI: disp_word[15:8] <= in_byte;
                    // one-byte group immediates widen by sign only when s:w=11
                    tad_pkg::ST_IMM_LO:
                        imm_word <= {ext_hi, in_byte};
                    tad_pkg::ST_IMM_HI: imm_word[15:8] <= in_byte;
                    default: state <= tad_pkg::ST_FIRST;
                endcase
            end
        end
    end

endmodule

// ---- test/tad_decoder_asserts.sv ----
`timescale 1ns/1ps
module tad_decoder_asserts (
    input wire logic             ref_clk,
    input wire logic             rst_b,
    input wire tad_pkg::tad_op_e insn_op,
    input wire logic             insn_valid,
    input wire logic             has_modrm,
    input wire logic             wide,
    input wire logic             sign_ext,
    input wire logic [2:0]       reg_field,
    input wire logic [15:0]      imm_word,
    input wire logic [2:0]       insn_len
);
    tad_pkg::tad_op_e op;
    assign op = insn_valid ? insn_op : tad_pkg::OP_OTHER;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // shape of finished translate, load, flag, adjust, add, sub, carry and borrow instructions
    // ------------------------------------------------------------
    a_translate_len: assert property (
        op == tad_pkg::table_translate_op |-> insn_len == 3'h1)
        else $error("translate length wrong");
    a_ptr_modrm: assert property (
        op inside {tad_pkg::load_effective_offset_op,
        tad_pkg::load_pointer_data_seg_op,
        tad_pkg::load_pointer_extra_seg_op} |-> has_modrm)
        else $error("pointer load lacks addressing byte");
    a_flag_single: assert property (
        op inside {tad_pkg::flags_to_high_acc_op,
        tad_pkg::high_acc_to_flags_op} |-> insn_len == 3'h1 && !has_modrm)
        else $error("flag move length wrong");
    a_adjust_single: assert property (
        op inside {tad_pkg::unpacked_add_adjust_op,
        tad_pkg::packed_add_adjust_op} |-> insn_len == 3'h1)
        else $error("adjust length wrong");
    a_addsub_modrm: assert property (
        op inside {tad_pkg::OP_ADD_RM, tad_pkg::OP_SUB_RM}
        |-> has_modrm && insn_len >= 3'h2)
        else $error("add or sub lacks addressing byte");
    a_carry_ext: assert property (
        op == tad_pkg::OP_ADC_IMM_RM |-> reg_field == 3'h2 && has_modrm)
        else $error("carry group extension wrong");
    a_borrow_ext: assert property (
        op == tad_pkg::OP_BORROW_IMM_RM |-> reg_field == 3'h3)
        else $error("borrow group extension wrong");
    a_byte_imm: assert property (
        op inside {tad_pkg::OP_ADC_ACC, tad_pkg::OP_BORROW_ACC} && !wide
        |-> imm_word[15:8] == 8'h00 && insn_len == 3'h2)
        else $error("byte immediate wrong");
    a_short_sext: assert property (
        op inside {tad_pkg::OP_ADC_IMM_RM, tad_pkg::OP_BORROW_IMM_RM}
        && sign_ext && wide |-> imm_word[15:8] == {8{imm_word[7]}})
        else $error("short immediate not extended");
    c_sext: cover property (op == tad_pkg::OP_BORROW_IMM_RM && sign_ext);
    c_translate: cover property (op == tad_pkg::table_translate_op);
    c_carry_acc: cover property (op == tad_pkg::OP_ADC_ACC && wide);
endmodule
bind tad_decoder tad_decoder_asserts u_chk (
    .ref_clk, .rst_b, .insn_op, .insn_valid, .has_modrm, .wide,
    .sign_ext, .reg_field, .imm_word, .insn_len);

// ---- test/tad_queue_model.sv ----
`timescale 1ns/1ps
module tad_queue_model (
    input  wire logic ref_clk,
    output logic      in_valid,
    output logic [7:0] in_byte
);
    initial begin
        in_valid = 1'b0;
        in_byte  = 8'h00;
    end
    task automatic put(input logic [7:0] b, input int gap);
        repeat (gap) begin
            @(negedge ref_clk);
            in_valid <= 1'b0;
            in_byte  <= ~in_byte;
        end
        @(negedge ref_clk);
        in_valid <= 1'b1;
        in_byte  <= b;
    endtask
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
    logic             ref_clk, rst_b, flush, in_valid, insn_valid;
    logic             wide, dir_to_reg, sign_ext, has_modrm;
    logic [7:0]       in_byte;
    logic [2:0]       reg_field, insn_len;
    logic [15:0]      imm_word;
    logic [31:0]      seed;
    tad_pkg::tad_op_e insn_op;
    int               mismatches, total_checks;
    localparam logic [7:0] BASE [16] = '{8'hd7, 8'h8d, 8'hc5, 8'hc4,
        8'h9f, 8'h9e, 8'h37, 8'h27, 8'h00, 8'h28, 8'h10, 8'h80, 8'h14,
        8'h18, 8'h80, 8'h1c};
    localparam tad_pkg::tad_op_e OPS [16] = '{
        tad_pkg::table_translate_op, tad_pkg::load_effective_offset_op,
        tad_pkg::load_pointer_data_seg_op, tad_pkg::load_pointer_extra_seg_op,
        tad_pkg::flags_to_high_acc_op, tad_pkg::high_acc_to_flags_op,
        tad_pkg::unpacked_add_adjust_op, tad_pkg::packed_add_adjust_op,
        tad_pkg::OP_ADD_RM, tad_pkg::OP_SUB_RM, tad_pkg::OP_ADC_RM,
        tad_pkg::OP_ADC_IMM_RM, tad_pkg::OP_ADC_ACC,
        tad_pkg::subtract_with_borrow_op, tad_pkg::OP_BORROW_IMM_RM,
        tad_pkg::OP_BORROW_ACC};
    tad_queue_model u_q (.ref_clk, .in_valid, .in_byte);
    tad_decoder u_dut (.ref_clk, .rst_b, .flush, .in_valid, .in_byte,
        .insn_op, .insn_valid, .wide, .dir_to_reg, .sign_ext, .has_modrm,
        .mode_field(), .reg_field, .rm_field(), .disp_word(), .imm_word,
        .insn_len);
    function automatic logic [31:0] nxt(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    function automatic logic [2:0] dlen(input logic [7:0] m);
        if (m[7:6] == 2'h1) return 3'h1;
        return (m[7:6] == 2'h2 || (m[7:6] == 2'h0 && m[2:0] == 3'h6))
            ? 3'h2 : 3'h0;
    endfunction
    task automatic chk(input string n, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // one instruction of form k; hard sets the masked low opcode bits (s:w=11 on group forms, w=1 on accumulator forms) and immediate 80
    task automatic run_one(input int k, input bit hard);
        logic [7:0] op, mr, lo;
        logic [2:0] len;
        logic [1:0] msk;
        bit md, grp, acc, two;
        seed = nxt(seed);
        acc = k == 12 || k == 15;
        grp = k == 11 || k == 14;
        md = !(k == 0 || (k >= 4 && k <= 7) || acc);
        msk = (k < 8) ? 2'h0 : acc ? 2'h1 : 2'h3;
        op = BASE[k] | {6'h0, (hard ? 2'h3 : seed[1:0]) & msk};
        mr = seed[15:8];
        if (grp) mr[5:3] = (k == 11) ? 3'h2 : 3'h3;
        lo = hard ? 8'h80 : seed[23:16];
        two = grp ? op[1:0] == 2'h1 : op[0];
        u_q.put(op, int'(seed[5:4]));
        len = 3'h1;
        if (md) begin
            u_q.put(mr, 0);
            len += 3'h1 + dlen(mr);
            repeat (dlen(mr)) u_q.put(seed[7:0], 0);
        end
        if (grp || acc) begin
            u_q.put(lo, 0);
            if (two) u_q.put(seed[31:24], 0);
            len += two ? 3'h2 : 3'h1;
        end
        @(posedge ref_clk);
        #1;
        chk("valid", 16'h1, 16'(insn_valid));
        chk("op", 16'(OPS[k]), 16'(insn_op));
        chk("len", 16'(len), 16'(insn_len));
        if (msk != 2'h0) chk("wide", 16'(op[0]), 16'(wide));
        if (msk == 2'h3 && !grp) chk("dir", 16'(op[1]), 16'(dir_to_reg));
        if (grp) chk("sext", 16'(op[1]), 16'(sign_ext));
        if (md) chk("reg", 16'(mr[5:3]), 16'(reg_field));
        if (grp || acc) chk("imm", two ? {seed[31:24], lo} :
            {(grp && &op[1:0]) ? {8{lo[7]}} : 8'h00, lo}, imm_word);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        wrap_up;
    end
    initial begin
        rst_b = 1'b0;
        flush = 1'b0;
        seed = 32'hbfbe;
        repeat (12) @(negedge ref_clk);
        chk("reset op", 16'h0, 16'(insn_op));
        rst_b = 1'b1;
        for (int i = 0; i < 16; i++) run_one(i, 1'b1);
        for (int i = 0; i < 400; i++) begin
            seed = nxt(seed);
            run_one(int'(seed[29:26]), 1'b0);
        end
        u_q.put(8'h80, 0);
        @(negedge ref_clk);
        flush <= 1'b1;
        u_q.put(8'hd7, 0);
        flush <= 1'b0;
        chk("flush valid", 16'h0, 16'(insn_valid));
        @(posedge ref_clk);
        #1;
        chk("flush op", 16'(OPS[0]), 16'(insn_op));
        wrap_up;
    end
endmodule
